// *** design/lagc_pkg.sv ***
// Constants for the left-channel record-path AGC: register map, fields, resets, limits.
// Assumes a 32-bit APB register bus with one register per aligned word.
package lagc_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_ENABLE_TARGET_HYST = 8'h56;
  localparam logic [7:0] IDX_HYST_NOISE_THRESHOLD = 8'h57;
  localparam logic [7:0] IDX_MAX_GAIN = 8'h58;
  localparam logic [7:0] IDX_ATTACK_TIME = 8'h59;
  localparam logic [7:0] IDX_STATUS = 8'h7E;

  // Field positions
  localparam int EN_BIT = 7;
  localparam int TARGET_LSB = 4;
  localparam int GHYST_LSB = 0;
  localparam int LHYST_LSB = 6;
  localparam int NOISE_LSB = 1;
  localparam int MAXG_LSB = 0;
  localparam int ATK_N_LSB = 3;
  localparam int ATK_K_LSB = 0;
  localparam int STAT_GAIN_LSB = 0;
  localparam int STAT_GATE_BIT = 8;
  localparam int STAT_RUN_BIT = 9;

  // Reset values
  localparam logic RST_EN = 1'b0;
  localparam logic [2:0] RST_TARGET = 3'h0;
  localparam logic [1:0] RST_GHYST = 2'h0;
  localparam logic [1:0] RST_LHYST = 2'h0;
  localparam logic [4:0] RST_NOISE = 5'h00;
  localparam logic [6:0] RST_MAXG = 7'h7F;
  localparam logic [4:0] RST_ATK_N = 5'h00;
  localparam logic [2:0] RST_ATK_K = 3'h0;

  // Gain limit and attack base unit, in half-dB steps and word clocks
  localparam logic [6:0] MAXG_LIMIT = 7'h74;
  localparam int ATK_BASE_SHIFT = 5;
  localparam int ATK_CNT_W = 18;

  // Level codes are signed half-dB values
  localparam int LVL_W = 9;
  localparam logic signed [8:0] NOISE_TOP = -9'sd60;
  localparam logic [1:0] LHYST_OFF = 2'h3;
endpackage : lagc_pkg

// *** design/lagc_attack_timer.sv ***
// Attack period timer counting ADC word-clock strobes.
// Assumes word_stb is a one-cycle pulse synchronous to pclk.
`timescale 1ns/1ps
module lagc_attack_timer
  import lagc_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic run,
  input wire logic word_stb,
  input wire logic [4:0] atk_n,
  input wire logic [2:0] atk_k,
  output logic tick_q
);
  logic [ATK_CNT_W-1:0] cnt_q;
  logic [ATK_CNT_W-1:0] cnt_d;
  logic [ATK_CNT_W-1:0] base_len;
  logic [ATK_CNT_W-1:0] period_len;
  logic last_w;

  // Base (2N+1)*32 scaled by 2^K, all in word clocks
  assign base_len = ATK_CNT_W'({atk_n, 1'b1}) << ATK_BASE_SHIFT;
  assign period_len = base_len << atk_k;
  assign last_w = (cnt_q >= period_len - ATK_CNT_W'(1));
  assign cnt_d = !run ? '0 : (word_stb ? (last_w ? '0 : cnt_q + ATK_CNT_W'(1)) : cnt_q);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q <= '0;
      tick_q <= 1'b0;
    end
    else if (ce)
    begin
      cnt_q <= cnt_d;
      tick_q <= run && word_stb && last_w;
    end
  end
endmodule : lagc_attack_timer

// *** design/lagc_left_agc.sv ***
// Left-channel record AGC: APB register file and gain stepping logic.
// Assumes synchronous inputs, a word-clock strobe and a measured level in signed half-dB.
`timescale 1ns/1ps
module lagc_left_agc
  import lagc_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic word_stb,
  input wire logic signed [LVL_W-1:0] level_in,
  output logic [6:0] agc_gain,
  output logic gate_active
);
  // Control fields
  logic en_q;
  logic [2:0] target_q;
  logic [1:0] ghyst_q;
  logic [1:0] lhyst_q;
  logic [4:0] noise_q;
  logic [6:0] maxg_q;
  logic [4:0] atk_n_q;
  logic [2:0] atk_k_q;

  // Bus response
  logic pready_q;
  logic pslverr_q;
  logic [31:0] prdata_q;

  // Gain path state
  logic signed [LVL_W-1:0] level_q;
  logic [6:0] want_q;
  logic [6:0] want_d;
  logic [6:0] gain_q;
  logic [6:0] gain_d;
  logic gate_q;
  logic tick;

  // Bus decode
  wire access_w = psel && penable;
  wire word_ok_w = (paddr[1:0] == 2'b00);
  wire [ADDR_W-3:0] idx_w = paddr[ADDR_W-1:2];
  wire hit_86_w = word_ok_w && (idx_w == (ADDR_W-2)'(IDX_ENABLE_TARGET_HYST));
  wire hit_87_w = word_ok_w && (idx_w == (ADDR_W-2)'(IDX_HYST_NOISE_THRESHOLD));
  wire hit_88_w = word_ok_w && (idx_w == (ADDR_W-2)'(IDX_MAX_GAIN));
  wire hit_89_w = word_ok_w && (idx_w == (ADDR_W-2)'(IDX_ATTACK_TIME));
  wire hit_st_w = word_ok_w && (idx_w == (ADDR_W-2)'(IDX_STATUS));
  wire mapped_w = hit_86_w || hit_87_w || hit_88_w || hit_89_w || hit_st_w;
  wire wr_ok_w = hit_86_w || hit_87_w || hit_88_w || hit_89_w;
  wire bad_w = !mapped_w || (pwrite && !wr_ok_w);
  // Write lands on the edge that samples pready high
  wire commit_w = access_w && pready_q;
  wire wr_w = commit_w && pwrite && !bad_w && pstrb[0];
  wire [7:0] wb_w = pwdata[7:0];
  wire tick_run_w = en_q;

  // Register images; reserved bits read zero
  wire [7:0] rd_86_w = {en_q, target_q, 2'b00, ghyst_q};
  wire [7:0] rd_87_w = {lhyst_q, noise_q, 1'b0};
  wire [7:0] rd_88_w = {1'b0, maxg_q};
  wire [7:0] rd_89_w = {atk_n_q, atk_k_q};
  wire [31:0] rd_st_w = {22'h0, tick_run_w, gate_q, 1'b0, gain_q};
  wire [31:0] rd_mux_w = hit_86_w ? {24'h000000, rd_86_w} :
                         hit_87_w ? {24'h000000, rd_87_w} :
                         hit_88_w ? {24'h000000, rd_88_w} :
                         hit_89_w ? {24'h000000, rd_89_w} :
                         hit_st_w ? rd_st_w : 32'h00000000;

  // Target level in half-dB
  logic signed [LVL_W-1:0] target_lvl_w;
  always_comb
  begin
    case (target_q)
      3'h0: target_lvl_w = -9'sd11;
      3'h1: target_lvl_w = -9'sd16;
      3'h2: target_lvl_w = -9'sd20;
      3'h3: target_lvl_w = -9'sd24;
      3'h4: target_lvl_w = -9'sd28;
      3'h5: target_lvl_w = -9'sd34;
      3'h6: target_lvl_w = -9'sd40;
      default: target_lvl_w = -9'sd48;
    endcase
  end

  // Level hysteresis band in half-dB
  logic signed [LVL_W-1:0] lhyst_w;
  always_comb
  begin
    case (lhyst_q)
      2'h0: lhyst_w = 9'sd2;
      2'h1: lhyst_w = 9'sd4;
      2'h2: lhyst_w = 9'sd8;
      default: lhyst_w = 9'sd0;
    endcase
  end

  // Noise threshold: -30 dB at code 1, 2 dB lower per step
  wire gate_on_w = (noise_q != 5'h00);
  wire signed [LVL_W-1:0] noise_lvl_w =
    NOISE_TOP - $signed({2'b00, noise_q - 5'h01, 2'b00});
  wire below_noise_w = gate_on_w && (level_q < noise_lvl_w);

  // Gain ceiling saturates at 58 dB
  wire [6:0] maxg_eff_w = (maxg_q > MAXG_LIMIT) ? MAXG_LIMIT : maxg_q;

  wire signed [LVL_W:0] hi_w = (LVL_W+1)'(target_lvl_w) + (LVL_W+1)'(lhyst_w);
  wire signed [LVL_W:0] lo_w = (LVL_W+1)'(target_lvl_w) - (LVL_W+1)'(lhyst_w);
  wire signed [LVL_W:0] lvl_x_w = (LVL_W+1)'(level_q);
  wire too_loud_w = lvl_x_w > hi_w;
  wire too_soft_w = lvl_x_w < lo_w;

  // Next wanted gain, one half-dB step per attack period
  always_comb
  begin
    want_d = want_q;
    if (!en_q)
    begin
      want_d = 7'h00;
    end
    else if (want_q > maxg_eff_w)
    begin
      want_d = maxg_eff_w;
    end
    else if (tick)
    begin
      if (too_loud_w && (want_q != 7'h00))
      begin
        want_d = want_q - 7'h01;
      end
      else if (too_soft_w && !below_noise_w && (want_q < maxg_eff_w))
      begin
        want_d = want_q + 7'h01;
      end
    end
  end

  // Gain hysteresis: applied gain moves only when outside the band, or to zero when disabled
  wire [6:0] diff_w = (want_q > gain_q) ? (want_q - gain_q) : (gain_q - want_q);
  always_comb
  begin
    gain_d = gain_q;
    if (!en_q)
    begin
      gain_d = 7'h00;
    end
    else if (diff_w > {5'h00, ghyst_q})
    begin
      gain_d = want_q;
    end
  end

  lagc_attack_timer u_attack_timer (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .run(tick_run_w),
    .word_stb(word_stb),
    .atk_n(atk_n_q),
    .atk_k(atk_k_q),
    .tick_q(tick)
  );

  // Bus response
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end
    else if (ce)
    begin
      pready_q <= access_w && !pready_q;
      pslverr_q <= access_w && !pready_q && bad_w;
      prdata_q <= (access_w && !pready_q && !pwrite) ? rd_mux_w : 32'h00000000;
    end
  end

  // Control registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      en_q <= RST_EN;
      target_q <= RST_TARGET;
      ghyst_q <= RST_GHYST;
      lhyst_q <= RST_LHYST;
      noise_q <= RST_NOISE;
      maxg_q <= RST_MAXG;
      atk_n_q <= RST_ATK_N;
      atk_k_q <= RST_ATK_K;
    end
    else if (ce && wr_w)
    begin
      if (hit_86_w)
      begin
        en_q <= wb_w[EN_BIT];
        target_q <= wb_w[TARGET_LSB +: 3];
        ghyst_q <= wb_w[GHYST_LSB +: 2];
      end
      if (hit_87_w)
      begin
        lhyst_q <= wb_w[LHYST_LSB +: 2];
        noise_q <= wb_w[NOISE_LSB +: 5];
      end
      if (hit_88_w)
      begin
        maxg_q <= wb_w[MAXG_LSB +: 7];
      end
      if (hit_89_w)
      begin
        atk_n_q <= wb_w[ATK_N_LSB +: 5];
        atk_k_q <= wb_w[ATK_K_LSB +: 3];
      end
    end
  end

  // Gain path
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      level_q <= '0;
      want_q <= 7'h00;
      gain_q <= 7'h00;
      gate_q <= 1'b0;
    end
    else if (ce)
    begin
      if (word_stb)
      begin
        level_q <= level_in;
      end
      want_q <= want_d;
      gain_q <= gain_d;
      gate_q <= en_q && below_noise_w;
    end
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign agc_gain = gain_q;
  assign gate_active = gate_q;
endmodule : lagc_left_agc

// *** sim/lagc_left_agc_checker.sv ***
// Checker for the left AGC block: bus answers and gain-path timing.
// Assumes it is bound to lagc_left_agc and sees only that module's ports.
`timescale 1ns/1ps
module lagc_left_agc_checker
  import lagc_pkg::*;
#(
  parameter int ADDR_W = 12
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic word_stb,
  input wire logic signed [LVL_W-1:0] level_in,
  input wire logic [6:0] agc_gain,
  input wire logic gate_active
);
  logic wr;
  logic en_q;
  logic nz_q;
  logic [7:0] cnt_q;
  logic rd_cfg;
  assign wr = psel && penable && pready && pwrite && pstrb[0] && !pslverr;
  // Status word is wider than one byte; only the AGC registers are byte-sized
  assign rd_cfg = paddr[ADDR_W-1:2] != (ADDR_W-2)'(IDX_STATUS);
  // Shadow of enable and noise code, and word strobes since the last gain change
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      en_q <= 1'b0;
      nz_q <= 1'b0;
      cnt_q <= 8'h00;
    end
    else
    begin
      if (wr && paddr == 12'h158)
        en_q <= pwdata[7];
      if (wr && paddr == 12'h15C)
        nz_q <= |pwdata[5:1];
      if ($changed(agc_gain))
        cnt_q <= 8'h00;
      else if (word_stb && cnt_q != 8'hFF)
        cnt_q <= cnt_q + 8'h01;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  AST_OFF_ZERO: assert property (!en_q [*3] |-> agc_gain == 7'h00 && !gate_active)
    else $error("gain active while off");
  AST_EN_START: assert property ($rose(en_q) |-> ##2 agc_gain == 7'h00)
    else $error("gain not zero on enable");
  AST_GATE_OFF: assert property (!nz_q [*2] |-> !gate_active)
    else $error("gate active with code zero");
  AST_GATE_HOLD: assert property (gate_active && $past(gate_active) |-> $stable(agc_gain))
    else $error("gain moved under gate");
  AST_CAP: assert property (agc_gain <= MAXG_LIMIT)
    else $error("gain above limit");
  AST_SPACING: assert property ($changed(agc_gain) && agc_gain != 7'h00 |-> cnt_q >= 8'h20)
    else $error("gain step too early");
  AST_RD_HIGH: assert property (pready && !pwrite && rd_cfg
    |-> prdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  AST_ERR_ZERO: assert property (pslverr |-> pready && prdata == 32'h00000000)
    else $error("refused answer malformed");
endmodule : lagc_left_agc_checker

bind lagc_left_agc lagc_left_agc_checker #(.ADDR_W(ADDR_W)) i_lagc_left_agc_checker (
  .pclk(pclk),
  .presetn(presetn),
  .ce(ce),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .pwdata(pwdata),
  .pstrb(pstrb),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .word_stb(word_stb),
  .level_in(level_in),
  .agc_gain(agc_gain),
  .gate_active(gate_active)
);

// *** sim/lagc_left_agc_tb_top.sv ***
// Testbench for the left AGC block: registers, attack timing, gain cap, noise gate.
// Assumes the checker file is compiled with it and binds itself.
`timescale 1ns/1ps
module lagc_left_agc_tb_top
  import lagc_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic ce = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic word_stb = 1'b0;
  logic signed [8:0] level_in = 9'h000;
  logic [6:0] agc_gain;
  logic gate_active;
  int fails = 0;
  int samples_checked = 0;
  logic [31:0] seed = 32'h0000DFF2;
  logic [31:0] r;
  logic e;
  logic [7:0] ix [4] = '{8'h56, 8'h57, 8'h58, 8'h59};
  logic [7:0] mk [4] = '{8'hF3, 8'hFE, 8'h7F, 8'hFF};
  logic [7:0] sh [4] = '{8'h00, 8'h00, 8'h7F, 8'h00};
  always #50 pclk = ~pclk;
  lagc_left_agc #(.ADDR_W(12)) i_lagc_left_agc (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .word_stb(word_stb),
    .level_in(level_in),
    .agc_gain(agc_gain),
    .gate_active(gate_active)
  );
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic int atk(input int n, input int k);
    return (2 * n + 1) * 32 << k;
  endfunction : atk
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    samples_checked++;
    if (g !== x)
    begin
      fails++;
      $display("Error %s expected %h seen %h", nm, x, g);
    end
  endtask : chk
  task automatic summarize();
    $display("checks %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : summarize
  // One APB transfer, entered just after a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    input logic [3:0] s, output logic [31:0] rd, output logic er);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, a, 2'b00};
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Idle cycle so the next call never reassigns psel in this time step
    @(posedge pclk);
  endtask : apb
  task automatic stb(input int n);
    repeat (n)
    begin
      word_stb <= 1'b1;
      @(posedge pclk);
      word_stb <= 1'b0;
      repeat (3) @(posedge pclk);
    end
  endtask : stb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'h1, r, e);
  endtask : wr
  initial
  begin
    int k;
    logic [31:0] d;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b0, ix[i], 32'h0, 4'h0, r, e);
      chk("reset", {24'h0, sh[i]}, r);
    end
    repeat (24)
    begin
      k = rnd() % 4;
      d = rnd();
      apb(1'b1, ix[k], d, d[11:8], r, e);
      if (d[8])
        sh[k] = d[7:0] & mk[k];
      apb(1'b0, ix[k], 32'h0, 4'h0, r, e);
      chk("readback", {24'h0, sh[k]}, r);
    end
    apb(1'b0, 8'h55, 32'h0, 4'h0, r, e);
    chk("refused", 32'h1, {31'h0, e});
    for (int t = 0; t < 3; t++)
    begin
      wr(8'h57, 32'h000000C0);
      wr(8'h58, 32'h00000074);
      wr(8'h59, t * 9);
      wr(8'h56, 32'h00000000);
      wr(8'h56, 32'h00000080);
      level_in <= -9'sd80 - 9'(rnd() & 32'h0000000F);
      k = 0;
      while (agc_gain === 7'h00 && k < 2000)
      begin
        stb(1);
        k++;
      end
      chk("attack", atk(t, t), k);
    end
    wr(8'h58, 32'h0000007F);
    wr(8'h59, 32'h00000000);
    stb(3800);
    chk("cap", 32'h74, agc_gain);
    apb(1'b0, IDX_STATUS, 32'h0, 4'h0, r, e);
    chk("status", 32'h274, r);
    // Target -20 dB (-40 half-dB), level band 1 dB, gain band 0.5 dB
    wr(8'h57, 32'h00000000);
    wr(8'h56, 32'h000000E1);
    level_in <= -9'sd39;
    stb(64);
    chk("band hold", 32'h74, agc_gain);
    level_in <= -9'sd37;
    stb(32);
    chk("gain band", 32'h74, agc_gain);
    stb(32);
    chk("step down", 32'h72, agc_gain);
    wr(8'h57, 32'h000000C2);
    level_in <= -9'sd70;
    stb(40);
    chk("gate on", 32'h1, gate_active);
    level_in <= -9'sd50;
    stb(40);
    chk("gate off", 32'h0, gate_active);
    // Clock enable low must freeze the gate state
    ce <= 1'b0;
    level_in <= -9'sd70;
    stb(40);
    chk("frozen", 32'h0, gate_active);
    ce <= 1'b1;
    wr(8'h57, 32'h000000C0);
    stb(40);
    chk("gate unused", 32'h0, gate_active);
    wr(8'h56, 32'h00000000);
    repeat (3) @(posedge pclk);
    chk("off", 32'h0, agc_gain);
    summarize();
  end
  initial
  begin
    repeat (60000) @(posedge pclk);
    fails++;
    summarize();
  end
endmodule : lagc_left_agc_tb_top
